// ==== core/adc_host_pkg.sv ====
/*
 * package for the serial host port of an externally clocked converter:
 * timing counts, frame and command types.
 * assumes a 125 MHz ref_clk.
 */
package adc_host_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int REF_CLK_MHZ       = 125;
    localparam int SCLK_HALF_NS      = 80;
    localparam int SCLK_HALF_CYC     =
        (SCLK_HALF_NS * REF_CLK_MHZ) / 1000;
    localparam int WORD_BITS         = 24;
    localparam int BYTE_BITS         = 8;
    localparam int RESULT_BYTES      = 3;
    localparam int RDY_MASK_BIT      = 2;

    // ************************************************************
    // command and answer carriers
    // ************************************************************
    typedef enum logic [1:0] {
        OP_READ_RESULT = 2'h0,
        OP_READ_CTRL   = 2'h1,
        OP_READ_CAL    = 2'h2,
        OP_WRITE       = 2'h3
    } op_t;

    typedef struct packed {
        op_t         op;
        logic        sel_cal;
        logic [23:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic [23:0] rdata;
        logic        err;
    } rsp_t;

    typedef struct packed {
        logic sclk;
        logic read_frame_n;
        logic write_frame_n;
        logic register_select;
    } pins_t;

endpackage : adc_host_pkg

// ==== core/adc_host_port.sv ====
/*
 * host controller that drives the converter's serial port in external
 * clocking mode: generates the serial clock, frames, select line, and
 * shifts bytes msb first.
 * assumes the converter sits on the pins; serial_io_line is shared, so
 * the host drives it only during a write frame.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - no control readback when wiring is tied
// - write frame may be inverted read frame
// - never derive read frame from write frame
// - detect result by polling ready line
// - result moves as three byte frames
// - register reads ignore the ready line
// - select low with read frame for control
// - host sends write data msb first
// - register write is exactly 24 bits
// - write split into three byte loads
// - bytes kept msb first, no reversal needed
// - result read starts only when ready low
// - byte counter three, frame after ready
module adc_host_port #(
    parameter int HALF_CYC  = adc_host_pkg::SCLK_HALF_CYC,
    parameter int NBYTES    = adc_host_pkg::RESULT_BYTES,
    parameter bit TIED_WIRE = 1'b0
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire adc_host_pkg::cmd_t   cmd,
    output logic                      rsp_valid,
    output adc_host_pkg::rsp_t        rsp,
    input  wire logic                 result_ready_n,
    input  wire logic                 serial_io_line_i,
    output logic                      serial_io_line_o,
    output logic                      serial_io_line_oe,
    output adc_host_pkg::pins_t       pins
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] pin_s;

    adc_host_sync #(
        .W(2)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({result_ready_n, serial_io_line_i}),
        .sync_out (pin_s)
    );

    logic rdy_n_s;
    logic sdi_s;
    assign rdy_n_s = pin_s[1];
    assign sdi_s   = pin_s[0];

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_POLL  = 6'b000010,
        ST_FRAME = 6'b000100,
        ST_LOW   = 6'b001000,
        ST_HIGH  = 6'b010000,
        ST_GAP   = 6'b100000
    } st_t;

    typedef struct packed {
        st_t                 st;
        adc_host_pkg::op_t   op;
        logic [15:0]         div;
        logic [2:0]          bit_n;
        logic [1:0]          bytes_left;
        logic [23:0]         shreg;
        logic                rd;
        logic                sel;
        logic                sdo;
        logic                sdo_oe;
        logic                rsp_v;
        adc_host_pkg::rsp_t  rsp;
        adc_host_pkg::pins_t pins;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);
    localparam logic [1:0]  NB      = 2'(NBYTES);

    always_comb begin
        s_d       = s_q;
        s_d.rsp_v = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                s_d.pins = '{sclk: 1'b0, read_frame_n: 1'b1,
                    write_frame_n: 1'b1, register_select: 1'b1};
                s_d.sdo_oe = 1'b0;
                if (cmd_valid) begin
                    s_d.op         = cmd.op;
                    s_d.rd         = (cmd.op != adc_host_pkg::OP_WRITE);
                    s_d.shreg      = cmd.wdata;
                    s_d.sel        = cmd.sel_cal;
                    s_d.bytes_left = NB;
                    s_d.rsp.err    = TIED_WIRE &&
                        (cmd.op == adc_host_pkg::OP_READ_CTRL);
                    if (cmd.op == adc_host_pkg::OP_READ_RESULT) begin
                        s_d.st = ST_POLL;
                    end else begin
                        s_d.st = ST_FRAME;
                    end
                    if (TIED_WIRE && cmd.op == adc_host_pkg::OP_READ_CTRL)
                    begin
                        s_d.st    = ST_IDLE;
                        s_d.rsp_v = 1'b1;
                    end
                end
            end
            ST_POLL: begin
                if (!rdy_n_s) begin
                    s_d.st = ST_FRAME;
                end
            end
            ST_FRAME: begin
                // select low only for control access; with tied wiring
                // it follows the write frame
                s_d.pins.register_select =
                    !(s_q.op == adc_host_pkg::OP_READ_CTRL ||
                      (s_q.op == adc_host_pkg::OP_WRITE && !s_q.rsp.err
                       && (TIED_WIRE || !s_q.sel)));
                if (s_q.rd) begin
                    s_d.pins.read_frame_n = 1'b0;
                end else begin
                    s_d.pins.write_frame_n = 1'b0;
                    s_d.sdo_oe = 1'b1;
                    s_d.sdo    = s_q.shreg[23];
                end
                s_d.bit_n = 3'h0;
                s_d.div   = HALF_M1;
                s_d.st    = ST_LOW;
            end
            ST_LOW: begin
                if (s_q.div != 16'h0) begin
                    s_d.div = s_q.div - 16'h1;
                end else begin
                    s_d.pins.sclk = 1'b1;
                    s_d.div       = HALF_M1;
                    s_d.st        = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (s_q.div != 16'h0) begin
                    s_d.div = s_q.div - 16'h1;
                end else begin
                    s_d.pins.sclk = 1'b0;
                    s_d.div       = HALF_M1;
                    // sample read data late in the high phase
                    s_d.shreg = s_q.rd ? {s_q.shreg[22:0], sdi_s}
                                       : {s_q.shreg[22:0], 1'b0};
                    s_d.sdo   = s_q.shreg[22];
                    s_d.bit_n = s_q.bit_n + 3'h1;
                    s_d.st    = ST_LOW;
                    if (s_q.bit_n == 3'h7) begin
                        s_d.bytes_left = s_q.bytes_left - 2'h1;
                        s_d.st         = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                // frames close one cycle after the eighth falling edge,
                // so the converter sees that edge inside the frame
                s_d.pins.read_frame_n  = 1'b1;
                s_d.pins.write_frame_n = 1'b1;
                s_d.sdo_oe             = 1'b0;
                if (s_q.div != 16'h0) begin
                    s_d.div = s_q.div - 16'h1;
                end else if (s_q.bytes_left != 2'h0) begin
                    s_d.st = ST_FRAME;
                end else begin
                    s_d.pins.register_select = 1'b1;
                    s_d.rsp.rdata = s_q.rd ? s_q.shreg : 24'h0;
                    s_d.rsp_v     = 1'b1;
                    s_d.st        = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q      <= '0;
            s_q.st   <= ST_IDLE;
            s_q.op   <= adc_host_pkg::OP_READ_RESULT;
            s_q.pins <= '{sclk: 1'b0, read_frame_n: 1'b1,
                write_frame_n: 1'b1, register_select: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign cmd_ready         = (s_q.st == ST_IDLE);
    assign rsp_valid         = s_q.rsp_v;
    assign rsp               = s_q.rsp;
    assign pins              = s_q.pins;
    assign serial_io_line_o  = s_q.sdo;
    assign serial_io_line_oe = s_q.sdo_oe;

    // ************************************************************
    // checks
    // ************************************************************
    property p_idle_high;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == ST_IDLE) |-> (pins.read_frame_n && pins.write_frame_n
            && !pins.sclk);
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("frame active while idle");

    property p_no_both_frames;
        @(posedge ref_clk) disable iff (rst)
        !(!pins.read_frame_n && !pins.write_frame_n);
    endproperty
    a_no_both_frames: assert property (p_no_both_frames)
        else $error("both frames low");

    property p_poll_waits;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == ST_POLL && rdy_n_s) |=> (s_q.st == ST_POLL);
    endproperty
    a_poll_waits: assert property (p_poll_waits)
        else $error("result read began with ready high");

    property p_ctrl_sel_low;
        @(posedge ref_clk) disable iff (rst)
        (!pins.read_frame_n && s_q.op == adc_host_pkg::OP_READ_CTRL)
            |-> !pins.register_select;
    endproperty
    a_ctrl_sel_low: assert property (p_ctrl_sel_low)
        else $error("control read without select low");

    property p_sdo_only_write;
        @(posedge ref_clk) disable iff (rst)
        serial_io_line_oe |-> !pins.write_frame_n;
    endproperty
    a_sdo_only_write: assert property (p_sdo_only_write)
        else $error("data driven outside write frame");

    property p_byte_ends_frame;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == ST_HIGH && s_q.div == 16'h0 && s_q.bit_n == 3'h7)
            |=> (s_q.st == ST_GAP)
                ##1 (pins.read_frame_n && pins.write_frame_n);
    endproperty
    a_byte_ends_frame: assert property (p_byte_ends_frame)
        else $error("frame not closed after eighth bit");

    property p_three_bytes;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == ST_FRAME) |-> (s_q.bytes_left != 2'h0);
    endproperty
    a_three_bytes: assert property (p_three_bytes)
        else $error("extra byte framed");

    property p_start_count;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == ST_IDLE && cmd_valid && !s_d.rsp_v)
            |=> (s_q.bytes_left == NB);
    endproperty
    a_start_count: assert property (p_start_count)
        else $error("byte counter not loaded");

    property p_sclk_half;
        @(posedge ref_clk) disable iff (rst)
        $rose(pins.sclk) |-> pins.sclk [*2];
    endproperty
    a_sclk_half: assert property (p_sclk_half)
        else $error("serial clock high phase too short");

endmodule : adc_host_port
`default_nettype wire

// ==== core/adc_host_sync.sv ====
/*
 * two-flop synchroniser for a vector of pin inputs.
 * assumes inputs are asynchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_host_sync #(
    parameter int W = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : adc_host_sync
`default_nettype wire

// ==== testbench/adc_dev_model.sv ====
/*
 * behavioural converter on the far side of the host port: control,
 * calibration and result words behind one serial line.
 * assumes the bench resolves the shared data line from both enables.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_dev_model (
    input  wire logic                ref_clk,
    input  wire adc_host_pkg::pins_t pins,
    input  wire logic                sdi,
    output logic                     sdo,
    output logic                     sdo_oe,
    output logic                     result_ready_n
);
    // ************************************************************
    // registers and bit positions
    // ************************************************************
    logic [23:0] ctrl_q, cal_q, out_q, rsh, wsh;
    int          rcnt, wcnt;
    logic        from_out;

    initial begin
        {ctrl_q, cal_q, out_q, rsh, wsh} = '0;
        {rcnt, wcnt} = '0;
        from_out = 1'b0;
        result_ready_n = 1'b1;
        sdo = 1'b0;
    end

    assign sdo_oe = !pins.read_frame_n;

    // positions persist across frames so a word may be split
    always @(negedge pins.read_frame_n) begin
        if (rcnt == 0) begin
            from_out = pins.register_select && !result_ready_n;
            rsh = !pins.register_select ? ctrl_q
                : (from_out ? out_q : cal_q);
        end
        sdo = rsh[23 - rcnt];
    end

    always @(negedge pins.sclk) if (!pins.read_frame_n) begin
        rcnt = rcnt + 1;
        if (rcnt == 24) begin
            rcnt = 0;
            if (from_out) result_ready_n = 1'b1;
        end else sdo = rsh[23 - rcnt];
    end

    always @(posedge pins.sclk) if (!pins.write_frame_n) begin
        wsh = {wsh[22:0], sdi};
        wcnt = wcnt + 1;
        if (wcnt == 24) begin
            wcnt = 0;
            if (pins.register_select) cal_q = wsh;
            else ctrl_q = wsh;
        end
    end

    task automatic post(input logic [23:0] v, input int dly);
        repeat (dly) @(posedge ref_clk);
        out_q = v;
        result_ready_n = 1'b0;
    endtask : post
endmodule : adc_dev_model
`default_nettype wire

// ==== testbench/adc_host_port_test.sv ====
/*
 * self-checking bench for adc_host_port with a converter model.
 * assumes the package, the design and adc_dev_model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_host_port_test;
    localparam int HC = 3;
    logic                ref_clk = 1'b0;
    logic                rst = 1'b1;
    logic                cmd_valid = 1'b0;
    logic                cmd_ready, rsp_valid, rdy_n, sdo, sdo_oe;
    logic                h_o, h_oe, want_res = 1'b0, pat = 1'b0;
    adc_host_pkg::cmd_t  cmd = '0;
    adc_host_pkg::rsp_t  rsp;
    adc_host_pkg::pins_t pins;
    logic [49:0]         exp_q[$];
    logic [23:0]         v, w;
    logic [24:0]         ev;
    logic                t_valid;
    adc_host_pkg::rsp_t  t_rsp;
    int                  err_total = 0, n_compared = 0, cyc = 0, nfr = 0;
    int                  n_refused = 0;
    int                  seed = 32'hCB7B;
    // undriven line shows a changing pattern, never the last bit
    wire logic sio = h_oe ? h_o : (sdo_oe ? sdo : pat);

    adc_host_port #(.HALF_CYC(HC)) dut_u (.ref_clk(ref_clk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .result_ready_n(rdy_n),
        .serial_io_line_i(sio), .serial_io_line_o(h_o),
        .serial_io_line_oe(h_oe), .pins(pins));
    adc_dev_model dev_u (.ref_clk(ref_clk), .pins(pins), .sdi(sio),
        .sdo(sdo), .sdo_oe(sdo_oe), .result_ready_n(rdy_n));
    // second port with tied wiring, fed the same commands
    adc_host_port #(.HALF_CYC(HC), .TIED_WIRE(1'b1)) tied_u (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(), .cmd(cmd), .rsp_valid(t_valid), .rsp(t_rsp),
        .result_ready_n(rdy_n), .serial_io_line_i(sio),
        .serial_io_line_o(), .serial_io_line_oe(), .pins());

    // ************************************************************
    // clock, timeout, checking
    // ************************************************************
    always #4 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [24:0] e,
                       input logic [24:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask : chk

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    always @(posedge ref_clk) begin
        pat <= ~pat;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end

    always @(posedge ref_clk) if (rsp_valid === 1'b1) begin
        if (exp_q.size() == 0) chk("rsp", 'x, rsp);
        else begin
            ev = exp_q[0][24:0] & exp_q[0][49:25];
            chk("rsp", ev, rsp & exp_q[0][49:25]);
            void'(exp_q.pop_front());
        end
    end

    // tied wiring refuses every control read
    always @(posedge ref_clk) if (t_valid === 1'b1) begin
        if (t_rsp.err === 1'b1) n_refused++;
    end

    always @(negedge pins.read_frame_n or negedge pins.write_frame_n) begin
        nfr++;
        if (want_res) chk("ready_at_frame", 25'h0, {24'h0, rdy_n});
    end

    // ************************************************************
    // stimulus
    // ************************************************************
    task automatic xfer(input adc_host_pkg::op_t op, input logic sel,
                        input logic [23:0] d, input logic [24:0] e,
                        input logic [24:0] m);
        nfr = 0;
        exp_q.push_back({m, e});
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, sel_cal: sel, wdata: d};
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do @(posedge ref_clk); while (rsp_valid !== 1'b1);
        repeat (2) @(posedge ref_clk);
        chk("frames", 25'h3, 25'(nfr));
        chk("bit_phase", 25'h0, 25'(dev_u.wcnt + dev_u.rcnt));
        chk("idle_pins", 25'h7, {21'h0, pins});
    endtask : xfer

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("reset_pins", 25'h7, {21'h0, pins});
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            xfer(adc_host_pkg::OP_WRITE, !i[0], v, 25'h0, 25'h1);
            if (i == 5) dev_u.post(24'hA5C30F, 0);
            xfer(i[0] ? adc_host_pkg::OP_READ_CTRL
                      : adc_host_pkg::OP_READ_CAL,
                 !i[0], 24'h0, {v, 1'b0}, '1);
        end
        w = 24'hA5C30F;
        for (int i = 0; i < 4; i++) begin
            want_res = 1'b1;
            xfer(adc_host_pkg::OP_READ_RESULT, 1'b1, 24'h0,
                 {w, 1'b0}, '1);
            want_res = 1'b0;
            chk("ready_after", 25'h1, {24'h0, rdy_n});
            w = $random(seed);
            fork
                dev_u.post(w, $random(seed) & 255);
            join_none
        end
        chk("refused", 25'h3, 25'(n_refused));
        conclude();
    end
endmodule : adc_host_port_test
`default_nettype wire
